// ### common/gfa_regs.vh
`ifndef GFA_REGS_VH
`define GFA_REGS_VH
// Selector position encoding.
`define GFA_SEL_OFF       2'h0
`define GFA_SEL_RUN       2'h1
`define GFA_SEL_AUTO      2'h2
// Fault slot bit positions within the fault vector.
`define GFA_FLT_IDLE      0
`define GFA_FLT_ESTOP     1
`define GFA_FLT_OILW      2
`define GFA_FLT_OILS      3
`define GFA_FLT_CLTLOW    4
`define GFA_FLT_CLTHIW    5
`define GFA_FLT_CLTHIS    6
`define GFA_FLT_CUST0     7
`define GFA_NUM_FLT       11
// Displayed fault codes, ten bits wide.
`define GFA_CODE_IDLE     10'h065
`define GFA_CODE_ESTOP    10'h066
`define GFA_CODE_OILW     10'h0c8
`define GFA_CODE_OILS     10'h0c9
`define GFA_CODE_CLTLOW   10'h0d2
`define GFA_CODE_CLTHIW   10'h0d3
`define GFA_CODE_CLTHIS   10'h0d4
`define GFA_CODE_CUST0    10'h104
// Idle speed target in RPM.
`define GFA_IDLE_RPM      12'h320
// Display geometry.
`define GFA_DISP_LINES    2'h2
`define GFA_DISP_CHARS    5'h10
// Timing: debounce time in microseconds and lamp flash half period in milliseconds.
`define GFA_DEBOUNCE_US   10
`define GFA_FLASH_MS      500
`define GFA_CLK_MHZ       125
`define GFA_DEBOUNCE_CYC  (`GFA_DEBOUNCE_US * `GFA_CLK_MHZ)
`define GFA_FLASH_CYC     (`GFA_FLASH_MS * 1000 * `GFA_CLK_MHZ)
// Interrupt status register bits.
`define GFA_IRQ_WARN      0
`define GFA_IRQ_SHUT      1
`define GFA_IRQ_CLEAR     2
// Register offsets.
`define GFA_REG_CTRL      4'h0
`define GFA_REG_STATUS    4'h1
`define GFA_REG_LATCH     4'h2
`define GFA_REG_IRQSTAT   4'h3
`define GFA_REG_IRQMASK   4'h4
`define GFA_REG_CODE      4'h5
// Reset values.
`define GFA_CTRL_RST      4'h0
`define GFA_MASK_RST      3'h0
`endif

// ### core/gfa_annunciator.v
`include "gfa_regs.vh"
// How it works
// R01: Non-automatic lamp flashes continuously while selector is in off.
// R02: Warning lamp lights on any warning; its code goes to the display.
// R03: Local reset press clears corrected warnings while the set keeps running.
// R04: In auto, a remote reset cycle also clears corrected warnings.
// R05: Shutdown lamp lights on any shutdown; shutdowns latch until valid reset.
// R06: Local reset clears corrected shutdowns only with selector in off.
// R07: In auto, remote start removed then remote reset cycle clears shutdowns.
// R08: Emergency stop code 102 clears only by local reset, never remotely.
// R09: Standby sleep is refused while any fault remains latched.
// R10: Resets leave any fault whose condition is still present.
// R11: Any shutdown stops the engine and closes the breaker trip contact.
// R12: Display has two lines of sixteen characters, shared with menus.
// R13: Low oil pressure gives warning 200, then shutdown 201.
// R14: High coolant temperature gives warning 211, then shutdown 212.
// R15: Low coolant temperature gives warning 210 only.
// R16: Customer faults 260 to 263 each configurable as warning or shutdown.
// R17: Idle input in run raises 101, inhibits build-up, governs to 800 RPM.
// R18: Reset inputs are synchronised, debounced and act once per press cycle.
module gfa_annunciator #(
   parameter FLASH_CYC = `GFA_FLASH_CYC
) (
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire        clkEn,
   input  wire [1:0]  selPos,
   input  wire        resetSw,
   input  wire        remoteReset,
   input  wire        remoteStart,
   input  wire        estopIn,
   input  wire        idleIn,
   input  wire        oilLowWarn,
   input  wire        oilLowShut,
   input  wire        cltLowWarn,
   input  wire        cltHighWarn,
   input  wire        cltHighShut,
   input  wire [3:0]  custFault,
   input  wire        sleepReq,
   input  wire [3:0]  regAddr,
   input  wire [31:0] regWdata,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [31:0] regRdata,
   output wire        irq,
   output reg         nonAutoLamp,
   output wire        warnLamp,
   output wire        shutLamp,
   output wire        engineStop,
   output wire        breakerTrip,
   output wire        commonAlarm,
   output wire        buildUpInhibit,
   output wire [11:0] govSpeedRpm,
   output wire        idleActive,
   output wire        sleepOk,
   output reg  [9:0]  dispCode,
   output reg         dispShutdown,
   output reg         dispValid,
   output wire [1:0]  dispLines,
   output wire [4:0]  dispChars
);
   localparam NF = `GFA_NUM_FLT;

   // Internal state, and the nets that join the slot latches to the lamps and the bus.
   reg               rstA_ff;
   reg               rstB_ff;
   wire              rstN = rstB_ff;
   reg  [3:0]        ctrl_ff;
   reg  [2:0]        irqMask_ff;
   reg  [2:0]        irqStat_ff;
   reg  [31:0]       flashCnt_ff;
   reg               startSeenOff_ff;
   reg               prevWarnAny_ff;
   reg               prevShutAny_ff;
   wire              locPress;
   wire              remPress;
   wire              remRelease;
   wire [NF-1:0]     cond;
   wire [NF-1:0]     isShut;
   wire [NF-1:0]     latched;
   wire [NF-1:0]     clearReq;
   wire              localWarnClr;
   wire              localShutClr;
   wire              remoteWarnClr;
   wire              remoteShutClr;
   wire              inRun;
   wire              inAuto;
   wire              inOff;
   wire              warnAny;
   wire              shutAny;
   wire              anyClear;
   wire [2:0]        irqEvents;
   wire              irqReadClr;
   reg  [9:0]        nxt_code;
   reg               nxt_isShut;
   reg               nxt_valid;
   integer           k;

   // Reset release goes through two flops so downstream sees a clean synchronous deassertion.
   // These two flops ignore the clock enable, so reset still lifts while the rest is frozen.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rstA_ff <= 1'b0;
         rstB_ff <= 1'b0;
      end else begin
         rstA_ff <= 1'b1;
         rstB_ff <= rstA_ff;
      end
   end

   // Selector decode; the unused code 3 opens none of the three gates, so only the local warning clear stays live.
   assign inOff  = (selPos == `GFA_SEL_OFF);
   assign inRun  = (selPos == `GFA_SEL_RUN);
   assign inAuto = (selPos == `GFA_SEL_AUTO);

   // Both reset sources are filtered; only debounced edges are used, never the held level.
   // The local switch acts on its press edge, so the clear follows the push, not the let go.
   gfa_debounce u_debLocal (
      .clk          (clk_sys),
      .rstN         (rstN),
      .ce           (clkEn),
      .rawIn        (resetSw),
      .levelOut     (),
      .pressPulse   (locPress), // [R18]
      .releasePulse ()
   );

   // The remote line acts on its release, so one cycle means assert and then let go.
   gfa_debounce u_debRemote (
      .clk          (clk_sys),
      .rstN         (rstN),
      .ce           (clkEn),
      .rawIn        (remoteReset),
      .levelOut     (),
      .pressPulse   (remPress),
      .releasePulse (remRelease) // [R18]
   );

   // Remote reset counts as cycled on release, after an assertion seen while remote start was absent.
   // A remote start seen at any point of the cycle throws it away, so a running demand cannot be reset.
   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         startSeenOff_ff <= 1'b0;
      end else if (clkEn) begin
         if (remoteStart || !inAuto) begin
            startSeenOff_ff <= 1'b0; // [R07]
         end else if (remPress) begin
            startSeenOff_ff <= 1'b1;
         end else if (remRelease) begin
            startSeenOff_ff <= 1'b0;
         end
      end
   end

   // Clear qualifiers per reset source; each latch still refuses while its condition holds.
   assign localWarnClr  = locPress; // [R03]
   assign localShutClr  = locPress & inOff; // [R06]
   assign remoteWarnClr = remRelease & inAuto; // [R04]
   assign remoteShutClr = remRelease & inAuto & startSeenOff_ff & ~remoteStart; // [R07]

   // Fault conditions by slot; idle only counts in run.
   // Customer inputs enter as a group; their class comes from the control register below.
   assign cond[`GFA_FLT_IDLE]   = idleIn & inRun; // [R17]
   assign cond[`GFA_FLT_ESTOP]  = estopIn;
   assign cond[`GFA_FLT_OILW]   = oilLowWarn; // [R13]
   assign cond[`GFA_FLT_OILS]   = oilLowShut; // [R13]
   assign cond[`GFA_FLT_CLTLOW] = cltLowWarn; // [R15]
   assign cond[`GFA_FLT_CLTHIW] = cltHighWarn; // [R14]
   assign cond[`GFA_FLT_CLTHIS] = cltHighShut; // [R14]
   assign cond[NF-1:`GFA_FLT_CUST0] = custFault;

   // Slot class; customer slots follow the control register.
   assign isShut[`GFA_FLT_IDLE]   = 1'b0;
   assign isShut[`GFA_FLT_ESTOP]  = 1'b1;
   assign isShut[`GFA_FLT_OILW]   = 1'b0;
   assign isShut[`GFA_FLT_OILS]   = 1'b1;
   assign isShut[`GFA_FLT_CLTLOW] = 1'b0; // [R15]
   assign isShut[`GFA_FLT_CLTHIW] = 1'b0;
   assign isShut[`GFA_FLT_CLTHIS] = 1'b1;
   assign isShut[NF-1:`GFA_FLT_CUST0] = ctrl_ff; // [R16]

   // One latch per fault; emergency stop ignores the remote path.
   genvar g;
   generate
      for (g = 0; g < NF; g = g + 1) begin : gSlot
         if (g == `GFA_FLT_ESTOP) begin : gEstop
            // Emergency stop never takes the remote clear, whatever its class says.
            assign clearReq[g] = localShutClr; // [R08]
         end else begin : gNorm
            assign clearReq[g] = isShut[g] ? (localShutClr | remoteShutClr) // [R06]
                                           : (localWarnClr | remoteWarnClr);
         end
         // The latch only sees a clear that its source and the selector already allow.
         gfa_fault_slot u_slot (
            .clk      (clk_sys),
            .rstN     (rstN),
            .ce       (clkEn),
            .cond     (cond[g]),
            .clearReq (clearReq[g]), // [R10]
            .latched  (latched[g])
         );
      end
   endgenerate

   // Lamps and trip contacts follow the latches, so they hold until a valid reset.
   assign warnAny = |(latched & ~isShut);
   assign shutAny = |(latched & isShut);
   assign warnLamp    = warnAny; // [R02]
   assign shutLamp    = shutAny; // [R05]
   assign engineStop  = shutAny; // [R11]
   assign breakerTrip = shutAny; // [R11]
   assign commonAlarm = shutAny;
   // Standby is refused while any latch is set, warnings included.
   assign sleepOk     = sleepReq & ~(|latched); // [R09]

   // Idle mode only holds while the input is present; it is not latched for control purposes.
   assign idleActive     = cond[`GFA_FLT_IDLE];
   assign buildUpInhibit = idleActive; // [R17]
   assign govSpeedRpm    = idleActive ? `GFA_IDLE_RPM : 12'h000; // [R17]

   // Display size is fixed; the menus upstream share the same two lines.
   assign dispLines = `GFA_DISP_LINES; // [R12]
   assign dispChars = `GFA_DISP_CHARS;

   // Pick the message: lowest shutdown slot first, else lowest warning slot.
   // The loop walks down from the top slot, so the last hit, the lowest slot, is kept.
   always @* begin
      nxt_code   = 10'h000;
      nxt_isShut = 1'b0;
      nxt_valid  = 1'b0;
      for (k = NF - 1; k >= 0; k = k - 1) begin
         if (latched[k] && !isShut[k] && !shutAny) begin
            nxt_code  = slot_code(k);
            nxt_valid = 1'b1;
         end
         if (latched[k] && isShut[k]) begin
            nxt_code   = slot_code(k);
            nxt_isShut = 1'b1;
            nxt_valid  = 1'b1;
         end
      end
   end

   // Maps a slot number to its displayed code.
   function [9:0] slot_code;
      input integer s;
      integer       off;
      begin
         // Customer codes run on from the first customer slot, so only the low bits can differ.
         off = s - `GFA_FLT_CUST0;
         case (s)
            `GFA_FLT_IDLE:   slot_code = `GFA_CODE_IDLE;
            `GFA_FLT_ESTOP:  slot_code = `GFA_CODE_ESTOP;
            `GFA_FLT_OILW:   slot_code = `GFA_CODE_OILW;
            `GFA_FLT_OILS:   slot_code = `GFA_CODE_OILS;
            `GFA_FLT_CLTLOW: slot_code = `GFA_CODE_CLTLOW;
            `GFA_FLT_CLTHIW: slot_code = `GFA_CODE_CLTHIW;
            `GFA_FLT_CLTHIS: slot_code = `GFA_CODE_CLTHIS;
            default:         slot_code = `GFA_CODE_CUST0 + off[9:0];
         endcase
      end
   endfunction

   // Registered display outputs.
   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         dispCode     <= 10'h000;
         dispShutdown <= 1'b0;
         dispValid    <= 1'b0;
      end else if (clkEn) begin
         dispCode     <= nxt_code; // [R02]
         dispShutdown <= nxt_isShut;
         dispValid    <= nxt_valid;
      end
   end

   // Flash timer; the lamp is forced off outside the off position so it never sticks lit.
   // Each half period is FLASH_CYC enabled cycles; frozen cycles do not count toward it.
   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         flashCnt_ff <= 32'h00000000;
         nonAutoLamp <= 1'b0;
      end else if (clkEn) begin
         if (!inOff) begin
            flashCnt_ff <= 32'h00000000;
            nonAutoLamp <= 1'b0;
         end else if (flashCnt_ff == FLASH_CYC - 1) begin
            flashCnt_ff <= 32'h00000000;
            nonAutoLamp <= ~nonAutoLamp; // [R01]
         end else begin
            flashCnt_ff <= flashCnt_ff + 32'h00000001;
         end
      end
   end

   // Interrupt events: new warning, new shutdown, the warning or shutdown lamp going out. Set beats read-clear.
   assign anyClear = (prevWarnAny_ff & ~warnAny) | (prevShutAny_ff & ~shutAny);
   // Event bits are clear, new shutdown and new warning; a read clear loses to a new event.
   assign irqEvents  = {anyClear, shutAny & ~prevShutAny_ff, warnAny & ~prevWarnAny_ff};
   assign irqReadClr = regRd && (regAddr == `GFA_REG_IRQSTAT);
   assign irq = |(irqStat_ff & irqMask_ff);

   // Register writes, event capture and read data.
   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         ctrl_ff        <= `GFA_CTRL_RST;
         irqMask_ff     <= `GFA_MASK_RST;
         irqStat_ff     <= 3'h0;
         prevWarnAny_ff <= 1'b0;
         prevShutAny_ff <= 1'b0;
         regRdata       <= 32'h00000000;
      end else if (clkEn) begin
         prevWarnAny_ff <= warnAny;
         prevShutAny_ff <= shutAny;
         // Only the control and mask registers take writes; the rest ignore them.
         if (regWr) begin
            if (regAddr == `GFA_REG_CTRL) begin
               ctrl_ff <= regWdata[3:0];
            end else if (regAddr == `GFA_REG_IRQMASK) begin
               irqMask_ff <= regWdata[2:0];
            end
         end
         irqStat_ff <= (irqReadClr ? 3'h0 : irqStat_ff) | irqEvents;
         // Read data stand for one cycle only and fall back to zero after it.
         regRdata <= 32'h00000000;
         if (regRd) begin
            if (regAddr == `GFA_REG_CTRL) begin
               regRdata <= {28'h0000000, ctrl_ff};
            end else if (regAddr == `GFA_REG_STATUS) begin
               regRdata <= {25'h0000000, selPos, sleepOk, idleActive, nonAutoLamp, shutAny, warnAny};
            end else if (regAddr == `GFA_REG_LATCH) begin
               regRdata <= {21'h000000, latched};
            end else if (regAddr == `GFA_REG_IRQSTAT) begin
               regRdata <= {29'h00000000, irqStat_ff};
            end else if (regAddr == `GFA_REG_IRQMASK) begin
               regRdata <= {29'h00000000, irqMask_ff};
            end else if (regAddr == `GFA_REG_CODE) begin
               regRdata <= {21'h000000, dispValid, dispCode};
            end else begin
               regRdata <= 32'h00000000;
            end
         end
      end
   end
endmodule

// ### core/gfa_debounce.v
`include "gfa_regs.vh"
// Synchronises and debounces one input; pulses on press and on release edges.
module gfa_debounce #(
   parameter CNT_W = 11,
   parameter [CNT_W-1:0] DEB_CYC = `GFA_DEBOUNCE_CYC
) (
   input  wire clk,
   input  wire rstN,
   input  wire ce,
   input  wire rawIn,
   output reg  levelOut,
   output reg  pressPulse,
   output reg  releasePulse
);
   reg             syncA_ff;
   reg             syncB_ff;
   reg [CNT_W-1:0] cnt_ff;

   // Two-stage synchroniser then a stability counter, so contact bounce cannot make many pulses.
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         syncA_ff     <= 1'b0;
         syncB_ff     <= 1'b0;
         cnt_ff       <= {CNT_W{1'b0}};
         levelOut     <= 1'b0;
         pressPulse   <= 1'b0;
         releasePulse <= 1'b0;
      end else if (ce) begin
         syncA_ff     <= rawIn;
         syncB_ff     <= syncA_ff;
         pressPulse   <= 1'b0;
         releasePulse <= 1'b0;
         if (syncB_ff == levelOut) begin
            cnt_ff <= {CNT_W{1'b0}};
         end else if (cnt_ff == DEB_CYC - 1'b1) begin
            cnt_ff       <= {CNT_W{1'b0}};
            levelOut     <= syncB_ff;
            pressPulse   <= syncB_ff;
            releasePulse <= ~syncB_ff;
         end else begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end
endmodule

// ### core/gfa_fault_slot.v
`include "gfa_regs.vh"
// One fault latch: set by its condition, cleared only by a qualified reset once corrected.
module gfa_fault_slot (
   input  wire clk,
   input  wire rstN,
   input  wire ce,
   input  wire cond,
   input  wire clearReq,
   output reg  latched
);
   // A present condition always wins over a clear, so uncorrected faults survive reset requests.
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         latched <= 1'b0;
      end else if (ce) begin
         if (cond) begin
            latched <= 1'b1;
         end else if (clearReq) begin
            latched <= 1'b0;
         end
      end
   end
endmodule

// ### dv/gfa_annunciator_properties.sv
`include "gfa_regs.vh"
// Watches the annunciator ports for lamp, shutdown and idle relations.
module gfa_annunciator_chk #(
   parameter FLASH_CYC = 8
) (
   input wire        clk_sys,
   input wire        reset_n,
   input wire        clkEn,
   input wire [1:0]  selPos,
   input wire        oilLowWarn,
   input wire        oilLowShut,
   input wire        idleIn,
   input wire        sleepReq,
   input wire        regRd,
   input wire [31:0] regRdata,
   input wire        nonAutoLamp,
   input wire        warnLamp,
   input wire        shutLamp,
   input wire        engineStop,
   input wire        breakerTrip,
   input wire        commonAlarm,
   input wire        buildUpInhibit,
   input wire [11:0] govSpeedRpm,
   input wire        idleActive,
   input wire        sleepOk,
   input wire [1:0]  dispLines,
   input wire [4:0]  dispChars
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [1:0]  upCnt_ff;
   reg        lampPrev_ff;
   reg [31:0] stay_ff;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // The internal reset lags the pin by two edges, so latch checks wait for this count.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         upCnt_ff <= 2'h0;
         lampPrev_ff <= 1'b0;
         stay_ff <= 32'h0;
      end else begin
         upCnt_ff <= (upCnt_ff == 2'h3) ? upCnt_ff : upCnt_ff + 2'h1;
         lampPrev_ff <= nonAutoLamp;
         stay_ff <= (clkEn && selPos == `GFA_SEL_OFF && nonAutoLamp == lampPrev_ff) ? stay_ff + 32'h1 : 32'h0;
      end
   end
   sequence setS(c);
      c && clkEn && upCnt_ff == 2'h3;
   endsequence
   shut_latch_a: assert property (setS(oilLowShut) |=> shutLamp) else $error("shutdown not latched");
   warn_latch_a: assert property (setS(oilLowWarn) |=> warnLamp) else $error("warning not latched");
   shut_hold_a: assert property (shutLamp && selPos == `GFA_SEL_RUN |=> shutLamp)
      else $error("shutdown lost");
   shut_outs_a: assert property (shutLamp == engineStop && shutLamp == breakerTrip
      && shutLamp == commonAlarm) else $error("stop outputs differ");
   idle_mode_a: assert property (upCnt_ff == 2'h3 |-> idleActive == (idleIn && selPos == `GFA_SEL_RUN)
      && buildUpInhibit == idleActive && govSpeedRpm == (idleActive ? `GFA_IDLE_RPM : 12'h000))
      else $error("idle outputs wrong");
   sleep_gate_a: assert property (sleepOk |-> sleepReq && !warnLamp && !shutLamp)
      else $error("sleep with fault");
   disp_size_a: assert property (dispLines == 2'h2 && dispChars == 5'h10) else $error("display size wrong");
   lamp_off_a: assert property (clkEn && selPos != `GFA_SEL_OFF |=> !nonAutoLamp) else $error("lamp lit");
   lamp_flash_a: assert property (stay_ff <= FLASH_CYC + 2) else $error("lamp not flashing");
   read_idle_a: assert property (!regRd && clkEn |=> regRdata == 32'h0) else $error("read data left standing");
endmodule

// ### dv/gfa_panel_model.sv
// Front panel and remote contacts: holds one reset line for a set time, then lets it settle.
module gfa_panel_model (
   input  wire logic        clk_sys,
   input  wire logic        goPress,
   input  wire logic        goRemote,
   input  wire logic [11:0] holdCyc,
   output logic             resetSw,
   output logic             remoteReset,
   output logic             busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [12:0] cnt;
   initial begin
      resetSw = 1'b0;
      remoteReset = 1'b0;
      busy = 1'b0;
      cnt = 13'h0;
   end
   // A contact is held whole and released; the settle tail covers the debounce of the release.
   always @(posedge clk_sys) begin
      if (goPress || goRemote) begin
         busy <= 1'b1;
         cnt <= 13'h514 + holdCyc;
         resetSw <= goPress;
         remoteReset <= goRemote;
      end else if (cnt != 13'h0) begin
         cnt <= cnt - 13'h1;
         if (cnt == 13'h514) begin
            resetSw <= 1'b0;
            remoteReset <= 1'b0;
         end
         if (cnt == 13'h1) begin
            busy <= 1'b0;
         end
      end
   end
endmodule

// ### dv/tb_genset_fault_annunciator.sv
`include "gfa_regs.vh"
module tb_genset_fault_annunciator;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, reset_n = 0, clkEn = 1, sleepReq = 1, remoteStart = 0;
   logic regWr = 0, regRd = 0, goP = 0, goR = 0, busy, pl, resetSw, remoteReset;
   logic irq, nonAutoLamp, warnLamp, shutLamp, engineStop, breakerTrip, commonAlarm;
   logic buildUpInhibit, idleActive, sleepOk, dispShutdown, dispValid;
   logic [1:0]  selPos = 0, dispLines;
   logic [3:0]  regAddr = 0, ctrl;
   logic [4:0]  dispChars;
   logic [9:0]  dispCode;
   logic [10:0] flt = 0;
   logic [11:0] hold = 0, govSpeedRpm;
   logic [31:0] regWdata = 0, regRdata;
   int failures = 0, checked = 0, seed = 34578, i, n;
   always #4 clk_sys = ~clk_sys;
   gfa_annunciator #(.FLASH_CYC(8)) dut (.*, .idleIn(flt[0]), .estopIn(flt[1]), .oilLowWarn(flt[2]),
      .oilLowShut(flt[3]), .cltLowWarn(flt[4]), .cltHighWarn(flt[5]), .cltHighShut(flt[6]), .custFault(flt[10:7]));
   gfa_panel_model pm (.clk_sys(clk_sys), .goPress(goP), .goRemote(goR), .holdCyc(hold), .resetSw(resetSw),
      .remoteReset(remoteReset), .busy(busy));
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task tk(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1;
      @(posedge clk_sys);
      regWr <= 0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1;
      @(posedge clk_sys);
      regRd <= 0;
      #1;
      chk(regRdata, e);
   endtask
   task pulse(input int k);
      @(posedge clk_sys);
      flt[k] <= 1;
      @(posedge clk_sys);
      flt[k] <= 0;
      tk(3);
   endtask
   task press(input logic r, input logic [11:0] h);
      @(posedge clk_sys);
      hold <= h;
      goP <= !r;
      goR <= r;
      @(posedge clk_sys);
      goP <= 0;
      goR <= 0;
      #1;
      for (int w = 0; w < 3000 && busy; w++) @(posedge clk_sys);
      #1;
      if (busy) failures++;
   endtask
   function automatic logic [9:0] codeOf(input int k);
      case (k)
         1: codeOf = 10'h066;
         2: codeOf = 10'h0c8;
         3: codeOf = 10'h0c9;
         4: codeOf = 10'h0d2;
         5: codeOf = 10'h0d3;
         6: codeOf = 10'h0d4;
         default: codeOf = 10'h104 + k[9:0] - 10'h7;
      endcase
   endfunction
   function automatic logic isShut(input int k, input logic [3:0] c);
      isShut = k == 1 || k == 3 || k == 6 || (k >= 7 && c[k-7]);
   endfunction
   task report_and_stop;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence; a slip in any latch or gate shows as a wrong latch word.
   initial begin
      ctrl = $random(seed);
      repeat (3) @(posedge clk_sys);
      reset_n <= 1;
      tk(3);
      rd(`GFA_REG_CTRL, 32'h0);
      rd(`GFA_REG_IRQMASK, 32'h0);
      rd(4'hf, 32'h0);
      n = 0;
      pl = nonAutoLamp;
      for (i = 0; i < 32; i++) begin
         tk(1);
         n += (nonAutoLamp !== pl);
         pl = nonAutoLamp;
      end
      chk(n >= 3 && n <= 5, 1);
      wr(`GFA_REG_CTRL, ctrl);
      rd(`GFA_REG_CTRL, ctrl);
      for (i = 1; i < 11; i++) begin
         pulse(i);
         chk({dispValid, dispShutdown, dispCode}, {1'b1, isShut(i, ctrl), codeOf(i)});
         rd(`GFA_REG_CODE, {21'h000000, 1'b1, codeOf(i)});
         chk({shutLamp, engineStop, breakerTrip, warnLamp}, {{3{isShut(i, ctrl)}}, !isShut(i, ctrl)});
         press(0, 12'h514);
         rd(`GFA_REG_LATCH, 32'h0);
      end
      @(posedge clk_sys) selPos <= `GFA_SEL_RUN;
      pulse(3);
      pulse(2);
      press(0, 12'h514);
      rd(`GFA_REG_LATCH, 32'h8);
      rd(`GFA_REG_STATUS, 32'h22);
      @(posedge clk_sys) flt[0] <= 1;
      tk(2);
      chk({idleActive, buildUpInhibit, govSpeedRpm}, {2'b11, 12'h320});
      @(posedge clk_sys) flt[0] <= 0;
      tk(2);
      chk({idleActive, buildUpInhibit, govSpeedRpm}, 32'h0);
      rd(`GFA_REG_LATCH, 32'h9);
      @(posedge clk_sys) begin
         selPos <= `GFA_SEL_OFF;
         flt[3] <= 1;
      end
      press(0, 12'h514);
      rd(`GFA_REG_LATCH, 32'h8);
      @(posedge clk_sys) flt[3] <= 0;
      press(0, 12'h258);
      rd(`GFA_REG_LATCH, 32'h8);
      press(0, 12'h514);
      rd(`GFA_REG_LATCH, 32'h0);
      rd(`GFA_REG_IRQSTAT, 32'h7);
      wr(`GFA_REG_IRQMASK, 32'h1);
      rd(`GFA_REG_IRQMASK, 32'h1);
      pulse(3);
      chk(irq, 0);
      pulse(2);
      chk(irq, 1);
      rd(`GFA_REG_IRQSTAT, 32'h3);
      chk(irq, 0);
      press(0, 12'h514);
      chk(sleepOk, 1);
      @(posedge clk_sys) begin
         selPos <= `GFA_SEL_AUTO;
         remoteStart <= 1;
      end
      pulse(1);
      pulse(3);
      pulse(2);
      chk(sleepOk, 0);
      chk({dispShutdown, dispCode}, {1'b1, 10'h066});
      press(1, 12'h514);
      rd(`GFA_REG_LATCH, 32'ha);
      @(posedge clk_sys) remoteStart <= 0;
      press(1, 12'h514);
      rd(`GFA_REG_LATCH, 32'h2);
      @(posedge clk_sys) clkEn <= 0;
      pulse(2);
      @(posedge clk_sys) clkEn <= 1;
      tk(2);
      chk(warnLamp, 0);
      report_and_stop();
   end
   // Watchdog sized well past the full sequence.
   initial begin
      #640000;
      failures++;
      report_and_stop();
   end
endmodule
bind gfa_annunciator gfa_annunciator_chk #(.FLASH_CYC(FLASH_CYC)) chk (.*);
